// ===== design/branch_core.v
`timescale 1ns/10ps
`include "core_defines.vh"
module branch_core (
  input  wire        clock_in,
  input  wire        arst_n_in,
  input  wire [7:0]  code_data_in,
  output wire [15:0] code_addr_out,
  output wire [7:0]  accumulator_out,
  output wire        carry_out,
  output wire [15:0] wide_data_pointer_out,
  output wire [7:0]  stack_top_pointer_out,
  output wire        insn_done_out,
  output wire        unknown_op_out
);
  reg  [15:0] pc_reg;
  reg  [7:0]  op_reg;
  reg  [7:0]  b1_reg;
  reg  [7:0]  b2_reg;
  reg  [2:0]  cyc_reg;
  reg         ext_reg;
  reg  [15:0] tgt_reg;
  reg  [7:0]  stack_top_pointer;
  reg  [7:0]  data_pointer_low;
  reg  [7:0]  data_pointer_high;
  reg  [7:0]  accumulator_reg;
  reg  [7:0]  second_accumulator;
  reg  [7:0]  psw_reg;
  reg         done_reg;
  reg         unk_reg;
  reg  [7:0]  ram [0:255];

  reg  [1:0]  len;
  reg  [2:0]  base;
  reg         cond;
  reg         jmp;
  reg  [15:0] tgt;
  reg         dw_en;
  reg  [7:0]  dw_a;
  reg  [7:0]  dw_d;
  reg         cy_en;
  reg         cy_v;
  reg         call;
  reg         ret;
  reg         unk;
  reg         cj;
  reg  [7:0]  cmp_x;
  reg  [7:0]  cmp_y;
  reg  [7:0]  dec;

  // program memory answers combinationally at code_addr_out
  wire [7:0]  opc = (cyc_reg == 3'd0) ? code_data_in : op_reg;
  wire [7:0]  o1 = (cyc_reg == 3'd1) ? code_data_in : b1_reg;
  wire [7:0]  o2 = (cyc_reg == 3'd2) ? code_data_in : b2_reg;
  wire        fetch = (cyc_reg < {1'b0, len});
  wire [15:0] pc_inc = pc_reg + {15'h0000, fetch};
  wire        last = (cyc_reg == base - 3'd1);
  wire        cy = psw_reg[`PSW_CY];
  wire [1:0]  bank_sel = psw_reg[`PSW_BANK_HI:`PSW_BANK_LO];
  wire [7:0]  rn_addr = {3'b000, bank_sel, opc[2:0]};
  wire [7:0]  ri_ptr = ram[{3'b000, bank_sel, 2'b00, opc[0]}];
  wire [7:0]  bit_byte = o1[7] ? {o1[7:3], 3'b000} : {`BIT_RAM, o1[6:3]};
  wire [7:0]  bit_src = rd_dir(bit_byte);
  wire        bit_val = bit_src[o1[2:0]];
  wire [7:0]  bmask = 8'h01 << o1[2:0];

  // direct reads: low half is ram, high half the special registers
  function [7:0] rd_dir;
    input [7:0] a;
    begin
      if (!a[7]) begin
        rd_dir = ram[a];
      end else begin
        case (a)
          `SFR_STACK:  rd_dir = stack_top_pointer;
          `SFR_PTR_LO: rd_dir = data_pointer_low;
          `SFR_PTR_HI: rd_dir = data_pointer_high;
          `SFR_PSW:    rd_dir = {psw_reg[7:1], ^accumulator_reg};
          `SFR_ACCUM:  rd_dir = accumulator_reg;
          `SFR_ACCUM2: rd_dir = second_accumulator;
          default:  rd_dir = 8'h00;
        endcase
      end
    end
  endfunction

  function [15:0] rel_t;
    input [15:0] p;
    input [7:0]  r;
    begin
      rel_t = p + {{8{r[7]}}, r};
    end
  endfunction

  always @* begin
    len = 2'd1;
    base = `CYC_NOP;
    cond = 1'b0;
    jmp = 1'b0;
    tgt = pc_inc;
    dw_en = 1'b0;
    dw_a = o1;
    dw_d = 8'h00;
    cy_en = 1'b0;
    cy_v = cy;
    call = 1'b0;
    ret = 1'b0;
    unk = 1'b0;
    cj = 1'b0;
    cmp_x = accumulator_reg;
    cmp_y = o1;
    dec = 8'h00;
    casez (opc)
      `OP_NOP, `OP_NOP2: begin
        len = 2'd1;
      end
      `OP_ANLC, `OP_ANLCN, `OP_ORLC, `OP_ORLCN, `OP_MOVCB: begin
        len = 2'd2;
        base = `CYC_BIT;
        cy_en = 1'b1;
        case (opc)
          `OP_ANLC:  cy_v = cy & bit_val;
          `OP_ANLCN: cy_v = cy & ~bit_val;
          `OP_ORLC:  cy_v = cy | bit_val;
          `OP_ORLCN: cy_v = cy | ~bit_val;
          default:   cy_v = bit_val;
        endcase
      end
      `OP_MOVBC: begin
        len = 2'd2;
        base = `CYC_BIT;
        dw_en = 1'b1;
        dw_a = bit_byte;
        dw_d = (bit_src & ~bmask) | ({8{cy}} & bmask);
      end
      `OP_JC, `OP_JNC: begin
        len = 2'd2;
        base = `CYC_JC;
        cond = 1'b1;
        jmp = (opc == `OP_JC) ? cy : ~cy;
        tgt = rel_t(pc_inc, o1);
      end
      `OP_JB, `OP_JNB, `OP_JBC: begin
        len = 2'd3;
        base = `CYC_JB;
        cond = 1'b1;
        jmp = (opc == `OP_JNB) ? ~bit_val : bit_val;
        tgt = rel_t(pc_inc, o2);
        // bit cleared only when the branch is taken
        dw_en = (opc == `OP_JBC) & bit_val;
        dw_a = bit_byte;
        dw_d = bit_src & ~bmask;
      end
      `OP_AJMP, `OP_ACALL: begin
        len = 2'd2;
        base = `CYC_AJMP;
        jmp = 1'b1;
        call = opc[4];
        tgt = {pc_inc[15:11], opc[7:5], o1};
      end
      `OP_LJMP, `OP_LCALL: begin
        len = 2'd3;
        base = `CYC_LJMP;
        jmp = 1'b1;
        call = opc[4];
        tgt = {o1, o2};
      end
      `OP_RET, `OP_RETI: begin
        base = `CYC_RET;
        jmp = 1'b1;
        ret = 1'b1;
        tgt = {ram[stack_top_pointer], ram[stack_top_pointer - 8'h01]};
      end
      `OP_SJMP: begin
        len = 2'd2;
        base = `CYC_SJMP;
        jmp = 1'b1;
        tgt = rel_t(pc_inc, o1);
      end
      `OP_JMPI: begin
        base = `CYC_JMPI;
        jmp = 1'b1;
        tgt = {data_pointer_high, data_pointer_low} + {8'h00, accumulator_reg};
      end
      `OP_JZ, `OP_JNZ: begin
        len = 2'd2;
        base = `CYC_JC;
        cond = 1'b1;
        jmp = (opc == `OP_JZ) ? (accumulator_reg == 8'h00) : (accumulator_reg != 8'h00);
        tgt = rel_t(pc_inc, o1);
      end
      `OP_CJAD: begin
        cj = 1'b1;
        base = `CYC_CJD;
        cmp_y = rd_dir(o1);
      end
      `OP_CJAI: begin
        cj = 1'b1;
        base = `CYC_CJI;
      end
      `OP_CJRI: begin
        cj = 1'b1;
        base = `CYC_CJR;
        cmp_x = ram[ri_ptr];
      end
      `OP_CJRN: begin
        cj = 1'b1;
        base = `CYC_CJI;
        cmp_x = ram[rn_addr];
      end
      `OP_DJRN: begin
        len = 2'd2;
        base = `CYC_DJR;
        cond = 1'b1;
        dec = ram[rn_addr] - 8'h01;
        dw_en = 1'b1;
        dw_a = rn_addr;
        dw_d = dec;
        jmp = (dec != 8'h00);
        tgt = rel_t(pc_inc, o1);
      end
      `OP_DJD: begin
        len = 2'd3;
        base = `CYC_DJD;
        cond = 1'b1;
        dec = rd_dir(o1) - 8'h01;
        dw_en = 1'b1;
        dw_d = dec;
        jmp = (dec != 8'h00);
        tgt = rel_t(pc_inc, o2);
      end
      `OP_MOVDI: begin
        len = 2'd3;
        base = `CYC_MOVI;
        dw_en = 1'b1;
        dw_d = o2;
      end
      `OP_CLRC, `OP_SETBC: begin
        cy_en = 1'b1;
        cy_v = opc[4];
      end
      default: begin
        unk = 1'b1;
      end
    endcase
    // shared tail of the four compare forms; carry flags x below y
    if (cj) begin
      len = 2'd3;
      cond = 1'b1;
      jmp = (cmp_x != cmp_y);
      tgt = rel_t(pc_inc, o2);
      cy_en = 1'b1;
      cy_v = (cmp_x < cmp_y);
    end
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pc_reg <= 16'h0000;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      cyc_reg <= 3'd0;
      ext_reg <= 1'b0;
      tgt_reg <= 16'h0000;
      stack_top_pointer <= `RST_STACK;
      data_pointer_low <= `RST_ZERO;
      data_pointer_high <= `RST_ZERO;
      accumulator_reg <= `RST_ZERO;
      second_accumulator <= `RST_ZERO;
      psw_reg <= `RST_ZERO;
      done_reg <= 1'b0;
      unk_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unk_reg <= 1'b0;
      if (!ext_reg && cyc_reg == 3'd0) begin
        op_reg <= code_data_in;
      end
      if (!ext_reg && cyc_reg == 3'd1) begin
        b1_reg <= code_data_in;
      end
      if (!ext_reg && cyc_reg == 3'd2) begin
        b2_reg <= code_data_in;
      end
      if (ext_reg) begin
        // extra cycle of a taken conditional branch loads the target and raises insn_done_out
        pc_reg <= tgt_reg;
        ext_reg <= 1'b0;
        cyc_reg <= 3'd0;
        done_reg <= 1'b1;
      end else if (last) begin
        unk_reg <= unk;
        if (dw_en) begin
          if (!dw_a[7]) begin
            ram[dw_a] <= dw_d;
          end else begin
            case (dw_a)
              `SFR_STACK:  stack_top_pointer <= dw_d;
              `SFR_PTR_LO: data_pointer_low <= dw_d;
              `SFR_PTR_HI: data_pointer_high <= dw_d;
              `SFR_PSW:    psw_reg <= dw_d;
              `SFR_ACCUM:  accumulator_reg <= dw_d;
              `SFR_ACCUM2: second_accumulator <= dw_d;
              default:  psw_reg <= psw_reg;
            endcase
          end
        end
        // carry written after the status word so an explicit flag wins
        if (cy_en) begin
          psw_reg[`PSW_CY] <= cy_v;
        end
        if (call) begin
          // both bytes land above the old pointer, which moves up by two in the same cycle
          ram[stack_top_pointer + 8'h01] <= pc_inc[7:0];
          ram[stack_top_pointer + 8'h02] <= pc_inc[15:8];
          stack_top_pointer <= stack_top_pointer + 8'h02;
        end
        if (ret) begin
          stack_top_pointer <= stack_top_pointer - 8'h02;
        end
        if (jmp && cond) begin
          ext_reg <= 1'b1;
          tgt_reg <= tgt;
          pc_reg <= pc_inc;
          cyc_reg <= cyc_reg + 3'd1;
        end else begin
          pc_reg <= jmp ? tgt : pc_inc;
          cyc_reg <= 3'd0;
          done_reg <= 1'b1;
        end
      end else begin
        pc_reg <= pc_inc;
        cyc_reg <= cyc_reg + 3'd1;
      end
    end
  end

  assign code_addr_out = pc_reg;
  assign accumulator_out = accumulator_reg;
  assign carry_out = psw_reg[`PSW_CY];
  assign wide_data_pointer_out = {data_pointer_high, data_pointer_low};
  assign stack_top_pointer_out = stack_top_pointer;
  assign insn_done_out = done_reg;
  assign unknown_op_out = unk_reg;
endmodule

// ===== design/core_defines.vh
`ifndef CORE_DEFINES_VH
`define CORE_DEFINES_VH
// special-function register addresses
`define SFR_STACK  8'h81
`define SFR_PTR_LO 8'h82
`define SFR_PTR_HI 8'h83
`define SFR_PSW    8'hd0
`define SFR_ACCUM  8'he0
`define SFR_ACCUM2 8'hf0
// reset values
`define RST_STACK  8'h07
`define RST_ZERO   8'h00
// status word fields
`define PSW_CY      7
`define PSW_BANK_HI 4
`define PSW_BANK_LO 3
// bit-addressable ram starts at 0x20
`define BIT_RAM   4'h2
// opcodes
`define OP_NOP    8'h00
`define OP_NOP2   8'ha5
`define OP_ANLC   8'h82
`define OP_ANLCN  8'hb0
`define OP_ORLC   8'h72
`define OP_ORLCN  8'ha0
`define OP_MOVCB  8'ha2
`define OP_MOVBC  8'h92
`define OP_JC     8'h40
`define OP_JNC    8'h50
`define OP_JB     8'h20
`define OP_JNB    8'h30
`define OP_JBC    8'h10
`define OP_AJMP   8'b???00001
`define OP_ACALL  8'b???10001
`define OP_LJMP   8'h02
`define OP_LCALL  8'h12
`define OP_RET    8'h22
`define OP_RETI   8'h32
`define OP_SJMP   8'h80
`define OP_JMPI   8'h73
`define OP_JZ     8'h60
`define OP_JNZ    8'h70
`define OP_CJAD   8'hb5
`define OP_CJAI   8'hb4
`define OP_CJRI   8'b1011011?
`define OP_CJRN   8'b10111???
`define OP_DJRN   8'b11011???
`define OP_DJD    8'hd5
`define OP_MOVDI  8'h75
`define OP_CLRC   8'hc3
`define OP_SETBC  8'hd3
// base cycle counts (taken conditional branches add one)
`define CYC_NOP   3'd1
`define CYC_BIT   3'd2
`define CYC_JC    3'd2
`define CYC_JB    3'd3
`define CYC_AJMP  3'd3
`define CYC_LJMP  3'd4
`define CYC_RET   3'd5
`define CYC_SJMP  3'd3
`define CYC_JMPI  3'd3
`define CYC_CJD   3'd4
`define CYC_CJI   3'd3
`define CYC_CJR   3'd4
`define CYC_DJR   3'd2
`define CYC_DJD   3'd3
`define CYC_MOVI  3'd3
`endif

// ===== tb/code_rom.sv
`timescale 1ns/10ps
module code_rom (
  input  wire logic [15:0] addr_in,
  output wire logic [7:0]  data_out
);
  logic [7:0] mem [0:65535];
  // unloaded space reads as no-operation
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // asynchronous read: the core samples in the same cycle
  assign data_out = mem[addr_in];
endmodule

// ===== tb/core_checker_asserts.sv
`timescale 1ns/10ps
module core_checker (
  input wire logic        clock_in,
  input wire logic        arst_n_in,
  input wire logic [7:0]  code_data_in,
  input wire logic [15:0] code_addr_out,
  input wire logic [7:0]  accumulator_out,
  input wire logic        carry_out,
  input wire logic [15:0] wide_data_pointer_out,
  input wire logic [7:0]  stack_top_pointer_out,
  input wire logic        insn_done_out,
  input wire logic        unknown_op_out
);
  logic [7:0]  d1, d2, d3;
  logic [15:0] a1, a2, a3;
  wire         st = insn_done_out | unknown_op_out;
  wire  [15:0] rt = code_addr_out + 16'h0001 + {{8{code_data_in[7]}}, code_data_in};
  wire         tk = (code_data_in == 8'h40 && carry_out) || (code_data_in == 8'h50 && !carry_out)
                 || (code_data_in == 8'h60 && accumulator_out == 8'h00)
                 || (code_data_in == 8'h70 && accumulator_out != 8'h00);
  wire         cb = code_data_in == 8'h40 || code_data_in == 8'h50
                 || code_data_in == 8'h60 || code_data_in == 8'h70;
  // opcode and address history for multi-byte targets
  always_ff @(posedge clock_in) begin
    {d3, d2, d1} <= {d2, d1, code_data_in};
    {a3, a2, a1} <= {a2, a1, code_addr_out};
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  reset_vals_a: assert property (!$past(arst_n_in) |-> stack_top_pointer_out == 8'h07
    && accumulator_out == 8'h00 && wide_data_pointer_out == 16'h0000) else $error("reset values");
  nop_one_a: assert property (st && (code_data_in == 8'h00 || code_data_in == 8'ha5) |=>
    st && code_addr_out == $past(code_addr_out) + 16'h0001) else $error("nop length");
  short_jump_a: assert property (st && code_data_in == 8'h80 |->
    ##3 st && code_addr_out == $past(rt, 2)) else $error("short jump");
  cond_taken_a: assert property (st && cb && tk |->
    ##3 st && code_addr_out == $past(rt, 2)) else $error("taken branch");
  cond_skip_a: assert property (st && cb && !tk |-> ##1 !st ##1
    st && code_addr_out == $past(code_addr_out, 2) + 16'h0002) else $error("untaken branch");
  long_jump_a: assert property (st && code_data_in == 8'h02 |->
    ##4 st && code_addr_out == {d3, d2}) else $error("long jump");
  ind_jump_a: assert property (st && code_data_in == 8'h73 |-> ##3 st && code_addr_out ==
    $past(wide_data_pointer_out, 3) + {8'h00, $past(accumulator_out, 3)}) else $error("jump indirect");
  page_jump_a: assert property (st && code_data_in[3:0] == 4'h1 |-> ##3 st &&
    code_addr_out == (((a3 + 16'h0002) & 16'hf800) | {5'h00, d3[7:5], d2})) else $error("page jump");
  call_push_a: assert property (st && code_data_in[4:0] == 5'h11 |->
    ##3 stack_top_pointer_out == $past(stack_top_pointer_out, 3) + 8'h02) else $error("call stack");
  taken_c: cover property (st && cb && tk);
  skip_c: cover property (st && cb && !tk);
  call_c: cover property (st && code_data_in == 8'hb1);
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clock_in = 1'b0;
  logic        arst_n_in = 1'b0;
  wire  [7:0]  code_data_in, accumulator_out, stack_top_pointer_out;
  wire  [15:0] code_addr_out, wide_data_pointer_out;
  wire         carry_out, insn_done_out, unknown_op_out;
  int          err_total = 0;
  int          samples_checked = 0;
  always #20 clock_in = ~clock_in;
  branch_core dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .code_data_in(code_data_in),
    .code_addr_out(code_addr_out), .accumulator_out(accumulator_out), .carry_out(carry_out),
    .wide_data_pointer_out(wide_data_pointer_out), .stack_top_pointer_out(stack_top_pointer_out),
    .insn_done_out(insn_done_out), .unknown_op_out(unknown_op_out));
  code_rom rom (.addr_in(code_addr_out), .data_out(code_data_in));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // three bytes always; pad bytes are zero or overwritten by a later load
  task automatic put(input logic [15:0] a, input logic [23:0] v);
    for (int i = 0; i < 3; i++) rom.mem[a + 16'(i)] = v[23 - 8 * i -: 8];
  endtask
  task automatic step(input int cyc, input logic [15:0] nxt);
    int n;
    n = 0;
    do begin
      @(negedge clock_in);
      n++;
    end while (insn_done_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      $display("[FAIL] %0t no completion", $time);
      stop_test();
    end
    chk(16'(n), 16'(cyc), "cycles");
    chk(code_addr_out, nxt, "pc");
  endtask
  task automatic reset_check;
    chk({8'h00, stack_top_pointer_out}, 16'h0007, "sp");
    chk(wide_data_pointer_out, 16'h0000, "wide_data_pointer");
    chk({accumulator_out, 7'h00, carry_out}, 16'h0000, "acc");
  endtask
  task automatic nop_cond;
    step(1, 16'h0001);
    step(1, 16'h0002);
    step(3, 16'h0009);
    step(2, 16'h000b);
    step(1, 16'h000c);
    step(3, 16'h0010);
    step(2, 16'h0012);
  endtask
  task automatic compare_jump;
    step(3, 16'h0015);
    chk({8'h00, accumulator_out}, 16'h005a, "acc");
    step(3, 16'h0018);
    step(4, 16'h001e);
    chk({15'h0000, carry_out}, 16'h0000, "carry");
    step(3, 16'h0021);
    chk(wide_data_pointer_out, 16'h0004, "wide_data_pointer");
    step(3, 16'h005e);
    step(3, 16'h0070);
    step(4, 16'h1234);
  endtask
  task automatic call_loop;
    step(3, 16'h1520);
    chk({8'h00, stack_top_pointer_out}, 16'h0009, "sp");
    step(5, 16'h1236);
    step(4, 16'h123b);
    step(3, 16'h123e);
    step(3, 16'h123e);
    step(2, 16'h1240);
  endtask
  task automatic bit_ops;
    step(1, 16'h1241);
    step(2, 16'h1243);
    chk({15'h0000, carry_out}, 16'h0000, "carry");
    step(2, 16'h1245);
    chk({15'h0000, carry_out}, 16'h0001, "carry");
    step(4, 16'h124a);
    chk({8'h00, accumulator_out}, 16'h0058, "acc");
    step(3, 16'h124d);
    step(1, 16'h124e);
    chk({15'h0000, unknown_op_out}, 16'h0001, "unknown");
    step(5, 16'h1251);
    chk({15'h0000, carry_out}, 16'h0001, "carry");
    step(4, 16'h1254);
    chk({15'h0000, carry_out}, 16'h0000, "carry");
  endtask
  initial begin
    #1;
    put(16'h0001, 24'ha56005);
    put(16'h0009, 24'h701000);
    put(16'h000b, 24'hd34002);
    put(16'h0010, 24'h502000);
    put(16'h0012, 24'h75e05a);
    put(16'h0015, 24'hb45a10);
    put(16'h0018, 24'hb41103);
    put(16'h001e, 24'h758204);
    put(16'h0021, 24'h730000);
    put(16'h005e, 24'h801000);
    put(16'h0070, 24'h021234);
    put(16'h1234, 24'hb120d5);
    put(16'h1237, 24'hf00200);
    put(16'h123b, 24'h750002);
    put(16'h123c, 24'h0002d8);
    put(16'h123f, 24'hfed3b0);
    put(16'h1242, 24'he172e1);
    put(16'h1245, 24'h10e102);
    put(16'h124a, 24'h20e105);
    put(16'h124d, 24'h04b5f0);
    put(16'h1250, 24'h00b600);
    put(16'h1520, 24'h220000);
    repeat (4) @(negedge clock_in);
    reset_check();
    arst_n_in = 1'b1;
    nop_cond();
    compare_jump();
    call_loop();
    bit_ops();
    stop_test();
  end
endmodule
bind branch_core core_checker chk_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
  .code_data_in(code_data_in), .code_addr_out(code_addr_out), .accumulator_out(accumulator_out),
  .carry_out(carry_out), .wide_data_pointer_out(wide_data_pointer_out),
  .stack_top_pointer_out(stack_top_pointer_out), .insn_done_out(insn_done_out),
  .unknown_op_out(unknown_op_out));
